// ==== bench/sed_src_model.sv ====
// Data source model driving both data ports
`timescale 1ns/10ps
`default_nettype none
module sed_src_model #(
  parameter logic [63:0] PAT_A = 64'h0,
  parameter logic [63:0] PAT_B = 64'h0
) (
  output logic dclk,
  output logic [15:0] da,
  output logic [15:0] db
);
  initial begin
    dclk = 1'b0;
    da = 16'h0000;
    db = 16'h0000;
  end
  task automatic send_set(input logic [63:0] ea, input logic [63:0] eb);
    for (int n = 0; n < 4; n++) begin
      da = PAT_A[16*n+:16] ^ ea[16*n+:16];
      db = PAT_B[16*n+:16] ^ eb[16*n+:16];
      #40 dclk = ~dclk;
      #40;
    end
    // Inverse after the set so stale data never passes
    da = ~da;
    db = ~db;
  endtask
endmodule
`default_nettype wire

// ==== bench/sed_top_test.sv ====
// Self-checking bench for the sample error detector
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e, g) begin checks_done++; if ((g) !== (e)) begin \
  $display("[ERR] reg %h exp %h got %h", a, e, g); fail_count++; end end
module sed_top_test;
  localparam logic [63:0] PA = 64'h3c5a_96e1_0ff0_a55a;
  localparam logic [63:0] PB = 64'hc3a5_691e_f00f_5aa5;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic dclk;
  logic sel = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] da, db;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  int fail_count = 0;
  int checks_done = 0;
  always #5 clk = ~clk;
  sed_src_model #(.PAT_A(PA), .PAT_B(PB)) src (.dclk(dclk), .da(da),
    .db(db));
  sed_top dut (.clk(clk), .rst(rst), .data_clock_in(dclk), .data_a(da),
    .data_b(db), .port_select(sel), .reg_addr(addr), .reg_wr(wr),
    .reg_wdata(wdata), .reg_rd(rd), .reg_rdata(rdata));
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(a, e, rdata)
  endtask
  task automatic maps(input logic s, input logic [15:0] r,
    input logic [15:0] f);
    @(posedge clk);
    sel <= s;
    rchk(8'h41, r[7:0]);
    rchk(8'h42, r[15:8]);
    rchk(8'h43, f[7:0]);
    rchk(8'h44, f[15:8]);
  endtask
  // Status needs a few clocks after the last falling edge
  task automatic send(input logic [63:0] ea, input logic [63:0] eb);
    // Keep pin changes off the clock edge
    #1;
    src.send_set(ea, eb);
    repeat (6) @(posedge clk);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    wrap_up;
  end
  initial begin
    logic [63:0] pp;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rchk(8'h40, 8'h00);
    rchk(8'h45, 8'h00);
    $display("test reset done");
    for (int p = 0; p < 2; p++) begin
      pp = p ? PB : PA;
      @(posedge clk);
      sel <= p[0];
      for (int i = 0; i < 8; i++)
        wreg(8'h38 + i[7:0], pp[8*i+:8]);
    end
    rchk(8'h3f, PB[63:56]);
    $display("test patterns done");
    send(64'h1, 64'h0);
    rchk(8'h40, 8'h00);
    wreg(8'h40, 8'h80);
    send(64'h0, 64'h0);
    rchk(8'h40, 8'h81);
    $display("test pass done");
    send(64'h8000_0000_0000_0001, 64'h0);
    rchk(8'h40, 8'ha2);
    maps(1'b0, 16'h0001, 16'h8000);
    maps(1'b1, 16'h0000, 16'h0000);
    send(64'h0, 64'h0);
    rchk(8'h40, 8'ha1);
    $display("test port a done");
    send(64'h0, 64'h0000_0010_0000_0000);
    rchk(8'h40, 8'he4);
    maps(1'b1, 16'h0010, 16'h0000);
    maps(1'b0, 16'h0001, 16'h8000);
    $display("test port b done");
    wreg(8'h40, 8'h00);
    wreg(8'h41, 8'hff);
    rchk(8'h40, 8'h00);
    maps(1'b0, 16'h0000, 16'h0000);
    $display("test disable done");
    wreg(8'h40, 8'h88);
    repeat (7) send(64'h1, 64'h0);
    rchk(8'h40, 8'haa);
    send(64'h1, 64'h0);
    rchk(8'h40, 8'h88);
    maps(1'b0, 16'h0000, 16'h0000);
    $display("test auto clear done");
    wrap_up;
  end
endmodule
`default_nettype wire

// ==== hdl/sed_pkg.sv ====
// Constants for the sample error detector
package sed_pkg;
  localparam int unsigned SED_DW = 16;
  localparam int unsigned SED_NPORT = 2;
  localparam int unsigned SED_NSAMP = 4;
  localparam logic [7:0] SED_ADDR_PAT_BASE = 8'h38;
  localparam logic [7:0] SED_ADDR_CTRL = 8'h40;
  localparam logic [7:0] SED_ADDR_RISE_L = 8'h41;
  localparam logic [7:0] SED_ADDR_RISE_H = 8'h42;
  localparam logic [7:0] SED_ADDR_FALL_L = 8'h43;
  localparam logic [7:0] SED_ADDR_FALL_H = 8'h44;
  localparam logic [7:0] SED_CTRL_RESET = 8'h00;
  localparam int unsigned SED_BIT_EN = 7;
  localparam int unsigned SED_BIT_ERR_B = 6;
  localparam int unsigned SED_BIT_ERR_A = 5;
  localparam int unsigned SED_BIT_AUTO = 3;
  localparam int unsigned SED_BIT_FAIL_B = 2;
  localparam int unsigned SED_BIT_FAIL_A = 1;
  localparam int unsigned SED_BIT_PASS = 0;
  localparam logic [3:0] SED_AUTO_SETS = 4'h8;
  localparam int unsigned SED_PORT_A = 0;
  localparam int unsigned SED_PORT_B = 1;
endpackage

// ==== hdl/sed_sync.sv ====
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module sed_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// ==== hdl/sed_top.sv ====
// Sample error detector for the two data input ports
//
// Summary of operation
// - Compare only while enable bit 7 set
// - Bit 6 shows port B error seen
// - Bit 5 shows port A error seen
// - Auto-clear after eight sets when bit 3
// - Bit 2 is port B last-set fail
// - Bit 1 is port A last-set fail
// - Bit 0 is last-set pass
// - Rising-edge error map at 0x41/0x42
// - Falling-edge error map at 0x43/0x44
// - Select zero reads port A maps
// - Select one reads port B maps
// - Samples 0,2 on rising clock edge
// - Samples 1,3 on falling clock edge
`timescale 1ns/10ps
`default_nettype none
module sed_top #(
  parameter int unsigned DW = sed_pkg::SED_DW
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic data_clock_in,
  input wire logic [DW-1:0] data_a,
  input wire logic [DW-1:0] data_b,
  input wire logic port_select,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  localparam int unsigned NP = sed_pkg::SED_NPORT;
  localparam int unsigned NS = sed_pkg::SED_NSAMP;

  function automatic logic pat_hit(input logic [7:0] a);
    pat_hit = (a[7:3] == sed_pkg::SED_ADDR_PAT_BASE[7:3]);
  endfunction

  logic dci_s;
  logic dci_d;
  logic [2*DW-1:0] dat_s;
  logic [DW-1:0] dat [NP];
  logic ctrl_en;
  logic ctrl_auto;
  logic half;
  logic [3:0] set_cnt;
  logic pass;
  // Two bytes per sample word, so eight byte slots per port
  logic [7:0] pat [NP][2*NS];
  logic [DW-1:0] err_r [NP];
  logic [DW-1:0] err_f [NP];
  logic [NP-1:0] set_bad;
  logic [NP-1:0] det;
  logic [NP-1:0] fail;
  logic [NP-1:0] end_bad;

  // Data passes the same depth as the clock so edges stay aligned
  sed_sync #(.W(1)) u_sync_dci (
    .clk(clk),
    .rst(rst),
    .d(data_clock_in),
    .q(dci_s)
  );
  sed_sync #(.W(2*DW)) u_sync_dat (
    .clk(clk),
    .rst(rst),
    .d({data_b, data_a}),
    .q(dat_s)
  );
  assign dat[sed_pkg::SED_PORT_A] = dat_s[DW-1:0];
  assign dat[sed_pkg::SED_PORT_B] = dat_s[2*DW-1:DW];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dci_d <= 1'b0;
    end else begin
      dci_d <= dci_s;
    end
  end

  wire dci_rise = dci_s & ~dci_d;
  wire dci_fall = ~dci_s & dci_d;
  wire cmp_rise = dci_rise & ctrl_en;
  wire cmp_fall = dci_fall & ctrl_en;
  wire set_end = cmp_fall & half;
  wire auto_clr = ctrl_auto & set_end &
    (set_cnt == sed_pkg::SED_AUTO_SETS - 4'h1);
  wire clr = ~ctrl_en | auto_clr;
  // rising edge takes 0 or 2
  // falling edge takes 1 or 3
  wire [1:0] idx = {half, dci_fall};

  // Register port decode
  wire wr_ctrl = reg_wr & (reg_addr == sed_pkg::SED_ADDR_CTRL);
  wire wr_pat = reg_wr & pat_hit(reg_addr);
  wire [2:0] pat_off = reg_addr[2:0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_en <= sed_pkg::SED_CTRL_RESET[sed_pkg::SED_BIT_EN];
      ctrl_auto <= sed_pkg::SED_CTRL_RESET[sed_pkg::SED_BIT_AUTO];
    end else if (wr_ctrl) begin
      ctrl_en <= reg_wdata[sed_pkg::SED_BIT_EN];
      ctrl_auto <= reg_wdata[sed_pkg::SED_BIT_AUTO];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pat <= '{default: '{default: 8'h00}};
    end else if (wr_pat) begin
      pat[port_select][pat_off] <= reg_wdata;
    end
  end

  // Sample phase and set count restart whenever detection is off
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      half <= 1'b0;
      set_cnt <= 4'h0;
    end else if (clr) begin
      half <= 1'b0;
      set_cnt <= 4'h0;
    end else if (cmp_fall) begin
      half <= ~half;
      set_cnt <= set_end ? set_cnt + 4'h1 : set_cnt;
    end
  end

  genvar p;
  generate
    for (p = 0; p < NP; p++) begin : g_port
      wire [DW-1:0] want = {pat[p][{idx, 1'b1}], pat[p][{idx, 1'b0}]};
      // any differing bit is an error
      wire [DW-1:0] miss = dat[p] ^ want;
      assign end_bad[p] = set_bad[p] | (|miss);

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          err_r[p] <= '0;
          err_f[p] <= '0;
          set_bad[p] <= 1'b0;
          det[p] <= 1'b0;
          fail[p] <= 1'b0;
        end else if (clr) begin
          err_r[p] <= '0;
          err_f[p] <= '0;
          set_bad[p] <= 1'b0;
          det[p] <= 1'b0;
          fail[p] <= 1'b0;
        end else if (cmp_rise) begin
          err_r[p] <= err_r[p] | miss;
          set_bad[p] <= set_bad[p] | (|miss);
        end else if (cmp_fall) begin
          err_f[p] <= err_f[p] | miss;
          set_bad[p] <= half ? 1'b0 : set_bad[p] | (|miss);
          if (half) begin
            fail[p] <= end_bad[p];
            det[p] <= det[p] | end_bad[p];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pass <= 1'b0;
    end else if (clr) begin
      pass <= 1'b0;
    end else if (set_end) begin
      pass <= ~(|end_bad);
    end
  end

  wire [DW-1:0] map_r = err_r[port_select];
  wire [DW-1:0] map_f = err_f[port_select];

  wire [7:0] ctrl_rd = {ctrl_en, det[sed_pkg::SED_PORT_B],
    det[sed_pkg::SED_PORT_A], 1'b0, ctrl_auto,
    fail[sed_pkg::SED_PORT_B], fail[sed_pkg::SED_PORT_A], pass};
  wire [7:0] pat_rd = pat[port_select][pat_off];
  wire [7:0] rd_mux =
    (reg_addr == sed_pkg::SED_ADDR_CTRL) ? ctrl_rd :
    (reg_addr == sed_pkg::SED_ADDR_RISE_L) ? map_r[7:0] :
    (reg_addr == sed_pkg::SED_ADDR_RISE_H) ? map_r[15:8] :
    (reg_addr == sed_pkg::SED_ADDR_FALL_L) ? map_f[7:0] :
    (reg_addr == sed_pkg::SED_ADDR_FALL_H) ? map_f[15:8] :
    pat_hit(reg_addr) ? pat_rd : 8'h00;

  // Read data held until the next read strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_EN_OFF: assert property (
    !ctrl_en |=> (err_r[0] == '0 && err_f[1] == '0 && !pass))
    else $error("maps not clear while detection off");
  AST_ERR_B: assert property (
    set_end && end_bad[1] && !auto_clr |=> det[1] && ctrl_rd[6])
    else $error("port B error bit not set");
  AST_ERR_A: assert property (
    set_end && end_bad[0] && !auto_clr |=> det[0] && ctrl_rd[5])
    else $error("port A error bit not set");
  AST_AUTO: assert property (
    auto_clr |=> set_cnt == 4'h0 && det == '0 && err_r[0] == '0)
    else $error("auto clear did not reset status");
  AST_FAIL_B: assert property (
    set_end && !auto_clr |=> fail[1] == $past(end_bad[1]))
    else $error("port B fail flag wrong");
  AST_FAIL_A: assert property (
    set_end && !auto_clr |=> fail[0] == $past(end_bad[0]))
    else $error("port A fail flag wrong");
  AST_PASS: assert property (
    set_end && !auto_clr |=> pass == !(fail[0] || fail[1]))
    else $error("pass flag disagrees with fail flags");
  AST_RMAP: assert property (
    reg_rd && reg_addr == sed_pkg::SED_ADDR_RISE_H
      |=> reg_rdata == $past(map_r[15:8]))
    else $error("rising map high byte misread");
  AST_FMAP: assert property (
    reg_rd && reg_addr == sed_pkg::SED_ADDR_FALL_L
      |=> reg_rdata == $past(map_f[7:0]))
    else $error("falling map low byte misread");
  AST_SEL_A: assert property (
    !port_select |-> map_r == err_r[0] && map_f == err_f[0])
    else $error("select zero not port A");
  AST_SEL_B: assert property (
    port_select |-> map_r == err_r[1] && map_f == err_f[1])
    else $error("select one not port B");
  AST_RISE_IDX: assert property (
    cmp_rise |-> idx[0] == 1'b0)
    else $error("rising edge used odd sample");
  AST_FALL_IDX: assert property (
    cmp_fall |-> idx[0] == 1'b1)
    else $error("falling edge used even sample");
endmodule
`default_nettype wire
